// *** hw/lpr_pkg.sv ***
// package: register map, field positions and reset values of the lane pll register bank
package lpr_pkg;
  localparam logic [9:0] LPR_OFS_EQ_BIAS      = 10'h268;
  localparam logic [9:0] LPR_OFS_PLL_ENABLE   = 10'h280;
  localparam logic [9:0] LPR_OFS_PLL_STATE    = 10'h281;
  localparam logic [9:0] LPR_OFS_FILTER_A     = 10'h284;
  localparam logic [9:0] LPR_OFS_FILTER_B     = 10'h285;
  localparam logic [9:0] LPR_OFS_FILTER_C     = 10'h286;
  localparam logic [9:0] LPR_OFS_PUMP_A       = 10'h287;
  localparam logic [9:0] LPR_OFS_REF_DIVIDE   = 10'h289;
  localparam logic [9:0] LPR_OFS_OSC_REG      = 10'h28a;
  localparam logic [9:0] LPR_OFS_POWERDOWN_A  = 10'h28b;
  localparam logic [9:0] LPR_OFS_VARACTOR_A   = 10'h290;

  localparam logic [7:0] LPR_RST_EQ_BIAS      = 8'h62;
  localparam logic [7:0] LPR_RST_FILTER_A     = 8'h77;
  localparam logic [7:0] LPR_RST_FILTER_B     = 8'h87;
  localparam logic [7:0] LPR_RST_FILTER_C     = 8'h08;
  localparam logic [7:0] LPR_RST_PUMP_A       = 8'h3f;
  localparam logic [7:0] LPR_RST_OSC_REG      = 8'h2b;
  localparam logic [7:0] LPR_RST_POWERDOWN_A  = 8'h7f;
  localparam logic [7:0] LPR_RST_VARACTOR_A   = 8'h83;

  localparam int LPR_EQ_PWR_HI     = 7;
  localparam int LPR_EQ_PWR_LO     = 6;
  localparam int LPR_BIT_TURN_ON   = 0;
  localparam int LPR_BIT_RECAL     = 2;
  localparam int LPR_BIT_CFG_FOUR  = 2;
  localparam int LPR_BIT_LOCKED    = 0;
  localparam int LPR_BIT_CAL_DONE  = 3;
  localparam int LPR_BIT_BAND_LOW  = 4;
  localparam int LPR_BIT_BAND_HIGH = 5;

  localparam logic [1:0] LPR_EQ_NORMAL    = 2'h0;
  localparam logic [1:0] LPR_EQ_LOW_POWER = 2'h1;
  localparam logic [1:0] LPR_DIV_BY4      = 2'h0;
  localparam logic [1:0] LPR_DIV_BY2      = 2'h1;
  localparam logic [1:0] LPR_DIV_BY1      = 2'h2;

  typedef enum logic [1:0] {LPR_PLL_OFF, LPR_PLL_CAL, LPR_PLL_RUN} lpr_pll_type;
endpackage : lpr_pkg

// *** hw/lpr_sync.sv ***
// three-flop synchroniser with agreement filter for one analog status level
`timescale 1ns/1ps
`default_nettype none
module lpr_sync (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output var  logic level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r      <= 1'b0;
      s2_r      <= 1'b0;
      s3_r      <= 1'b0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule // lpr_sync
`default_nettype wire

// *** hw/lpr_regs.sv ***
// lane pll control and status register bank with calibration sequencing
`timescale 1ns/1ps
`default_nettype none
module lpr_regs
  import lpr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic [9:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  output var  logic       reg_rvalid,
  input  wire logic       pll_lock_in,
  input  wire logic       pll_cal_ok_in,
  input  wire logic       pll_band_high_in,
  input  wire logic       pll_band_low_in,
  output var  logic       lane_pll_turn_on,
  output var  logic       lane_pll_cal_start,
  output var  logic [1:0] equalizer_power_select,
  output var  logic [5:0] equalizer_bias_trim,
  output var  logic [1:0] ref_predivide_select,
  output var  logic [2:0] ref_predivide_factor,
  output var  logic       ref_config_bit,
  output var  logic [7:0] lane_pll_filter_a,
  output var  logic [7:0] lane_pll_filter_b,
  output var  logic [7:0] lane_pll_filter_c,
  output var  logic [7:0] lane_pll_pump_a,
  output var  logic [7:0] lane_pll_osc_regulator,
  output var  logic [7:0] lane_pll_powerdown_a,
  output var  logic [7:0] lane_pll_varactor_a
);
  logic        recal_trigger_r;
  logic        lock_s;
  logic        cal_ok_s;
  logic        band_high_s;
  logic        band_low_s;
  logic        cal_req;
  logic [7:0]  state_byte;
  logic [7:0]  rd_nxt;
  lpr_pll_type pll_r;

  lpr_sync u_sync_lock (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .async_in  (pll_lock_in),
    .level_out (lock_s)
  );
  lpr_sync u_sync_cal (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .async_in  (pll_cal_ok_in),
    .level_out (cal_ok_s)
  );
  lpr_sync u_sync_high (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .async_in  (pll_band_high_in),
    .level_out (band_high_s)
  );
  lpr_sync u_sync_low (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .async_in  (pll_band_low_in),
    .level_out (band_low_s)
  );

  // eq bias register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      equalizer_power_select <= LPR_RST_EQ_BIAS[LPR_EQ_PWR_HI:LPR_EQ_PWR_LO];
      equalizer_bias_trim    <= LPR_RST_EQ_BIAS[5:0];
    end else if (clk_en && reg_wr && reg_addr == LPR_OFS_EQ_BIAS) begin
      equalizer_power_select <= reg_wdata[LPR_EQ_PWR_HI:LPR_EQ_PWR_LO];
      equalizer_bias_trim    <= reg_wdata[5:0];
    end
  end

  // enable control: bits 7:3 and 1 are not stored
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lane_pll_turn_on <= 1'b0;
      recal_trigger_r  <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == LPR_OFS_PLL_ENABLE) begin
      lane_pll_turn_on <= reg_wdata[LPR_BIT_TURN_ON];
      recal_trigger_r  <= reg_wdata[LPR_BIT_RECAL];
    end
  end

  // calibration starts on turn-on rising or recal rising while on
  always_comb begin
    cal_req = 1'b0;
    if (reg_wr && reg_addr == LPR_OFS_PLL_ENABLE) begin
      if (reg_wdata[LPR_BIT_TURN_ON] && !lane_pll_turn_on) begin
        cal_req = 1'b1;
      end
      if (reg_wdata[LPR_BIT_RECAL] && !recal_trigger_r && reg_wdata[LPR_BIT_TURN_ON]) begin
        cal_req = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pll_r              <= LPR_PLL_OFF;
      lane_pll_cal_start <= 1'b0;
    end else if (clk_en) begin
      lane_pll_cal_start <= cal_req;
      if (reg_wr && reg_addr == LPR_OFS_PLL_ENABLE && !reg_wdata[LPR_BIT_TURN_ON]) begin
        pll_r <= LPR_PLL_OFF;
      end else if (cal_req) begin
        pll_r <= LPR_PLL_CAL;
      end else begin
        case (pll_r)
          LPR_PLL_OFF: pll_r <= LPR_PLL_OFF;
          LPR_PLL_CAL: begin
            if (cal_ok_s && !lane_pll_cal_start) begin
              pll_r <= LPR_PLL_RUN;
            end
          end
          LPR_PLL_RUN: pll_r <= LPR_PLL_RUN;
          default:     pll_r <= LPR_PLL_OFF;
        endcase
      end
    end
  end

  // divider setup
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ref_predivide_select <= LPR_DIV_BY4;
      ref_config_bit       <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == LPR_OFS_REF_DIVIDE) begin
      ref_predivide_select <= reg_wdata[1:0];
      ref_config_bit       <= reg_wdata[LPR_BIT_CFG_FOUR];
    end
  end

  // decoded division factor, code 11 treated as divide by 1
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ref_predivide_factor <= 3'h4;
    end else if (clk_en) begin
      case (ref_predivide_select)
        LPR_DIV_BY4: ref_predivide_factor <= 3'h4;
        LPR_DIV_BY2: ref_predivide_factor <= 3'h2;
        LPR_DIV_BY1: ref_predivide_factor <= 3'h1;
        default:     ref_predivide_factor <= 3'h1;
      endcase
    end
  end

  // analog tuning registers, values chosen by software
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      lane_pll_filter_a      <= LPR_RST_FILTER_A;
      lane_pll_filter_b      <= LPR_RST_FILTER_B;
      lane_pll_filter_c      <= LPR_RST_FILTER_C;
      lane_pll_pump_a        <= LPR_RST_PUMP_A;
      lane_pll_osc_regulator <= LPR_RST_OSC_REG;
      lane_pll_powerdown_a   <= LPR_RST_POWERDOWN_A;
      lane_pll_varactor_a    <= LPR_RST_VARACTOR_A;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        LPR_OFS_FILTER_A:    lane_pll_filter_a      <= reg_wdata;
        LPR_OFS_FILTER_B:    lane_pll_filter_b      <= reg_wdata;
        LPR_OFS_FILTER_C:    lane_pll_filter_c      <= reg_wdata;
        LPR_OFS_PUMP_A:      lane_pll_pump_a        <= reg_wdata;
        LPR_OFS_OSC_REG:     lane_pll_osc_regulator <= reg_wdata;
        LPR_OFS_POWERDOWN_A: lane_pll_powerdown_a   <= reg_wdata;
        LPR_OFS_VARACTOR_A:  lane_pll_varactor_a    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // status flags forced low unless calibration finished
  always_comb begin
    state_byte = 8'h00;
    if (pll_r == LPR_PLL_RUN) begin
      state_byte[LPR_BIT_LOCKED]    = lock_s;
      state_byte[LPR_BIT_CAL_DONE]  = 1'b1;
    end
    if (pll_r != LPR_PLL_OFF && pll_r != LPR_PLL_CAL) begin
      state_byte[LPR_BIT_BAND_HIGH] = band_high_s;
      state_byte[LPR_BIT_BAND_LOW]  = band_low_s;
    end
  end

  always_comb begin
    rd_nxt = 8'h00;
    case (reg_addr)
      LPR_OFS_EQ_BIAS:     rd_nxt = {equalizer_power_select, equalizer_bias_trim};
      LPR_OFS_PLL_ENABLE:  rd_nxt = {5'h00, recal_trigger_r, 1'b0, lane_pll_turn_on};
      LPR_OFS_PLL_STATE:   rd_nxt = state_byte;
      LPR_OFS_FILTER_A:    rd_nxt = lane_pll_filter_a;
      LPR_OFS_FILTER_B:    rd_nxt = lane_pll_filter_b;
      LPR_OFS_FILTER_C:    rd_nxt = lane_pll_filter_c;
      LPR_OFS_PUMP_A:      rd_nxt = lane_pll_pump_a;
      LPR_OFS_REF_DIVIDE:  rd_nxt = {5'h00, ref_config_bit, ref_predivide_select};
      LPR_OFS_OSC_REG:     rd_nxt = lane_pll_osc_regulator;
      LPR_OFS_POWERDOWN_A: rd_nxt = lane_pll_powerdown_a;
      LPR_OFS_VARACTOR_A:  rd_nxt = lane_pll_varactor_a;
      default:             rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rd_nxt;
      end
    end
  end
endmodule // lpr_regs
`default_nettype wire

// *** sim/lpr_regs_assertions.sv ***
// port checks for the lane pll register bank
`timescale 1ns/1ps
`default_nettype none
module lpr_regs_assertions import lpr_pkg::*; (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       clk_en,
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       lane_pll_turn_on,
  input wire logic       lane_pll_cal_start,
  input wire logic [1:0] equalizer_power_select,
  input wire logic [5:0] equalizer_bias_trim,
  input wire logic [1:0] ref_predivide_select,
  input wire logic [2:0] ref_predivide_factor,
  input wire logic [7:0] lane_pll_filter_a
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire en_wr = clk_en && reg_wr && reg_addr == LPR_OFS_PLL_ENABLE;
  wire rd_en = clk_en && reg_rd;
  sequence s_turn_on; en_wr && reg_wdata[0] && !lane_pll_turn_on; endsequence
  sequence s_pulse; lane_pll_cal_start ##1 !lane_pll_cal_start; endsequence
  a_start_pulse: assert property (s_turn_on |=> s_pulse)
    else $error("no calibration start pulse");
  a_start_cause: assert property (lane_pll_cal_start |-> $past(en_wr && reg_wdata[0]))
    else $error("calibration start without enable write");
  a_turn_on_follow: assert property (en_wr |=> lane_pll_turn_on == $past(reg_wdata[0]))
    else $error("turn on level not written");
  a_read_answer: assert property (rd_en |=> reg_rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(rd_en))
    else $error("read valid without read");
  a_status_off: assert property (rd_en && reg_addr == LPR_OFS_PLL_STATE && !lane_pll_turn_on
    |=> reg_rdata == 8'h00) else $error("status not clear while off");
  a_reserved_zero: assert property (rd_en && reg_addr == LPR_OFS_PLL_ENABLE
    |=> reg_rdata[7:3] == 5'h00 && !reg_rdata[1]) else $error("reserved bits set");
  a_eq_write: assert property (clk_en && reg_wr && reg_addr == LPR_OFS_EQ_BIAS
    |=> equalizer_power_select == $past(reg_wdata[7:6])) else $error("eq field not written");
  a_reset_values: assert property ($rose(nrst) |-> equalizer_power_select == LPR_EQ_LOW_POWER
    && equalizer_bias_trim == 6'h22 && !lane_pll_turn_on && lane_pll_filter_a == LPR_RST_FILTER_A)
    else $error("bad reset values");
  a_div_decode: assert property (ref_predivide_factor == ($past(ref_predivide_select) == 2'h0 ?
    3'h4 : $past(ref_predivide_select) == 2'h1 ? 3'h2 : 3'h1)) else $error("bad divide factor");
endmodule // lpr_regs_assertions
bind lpr_regs lpr_regs_assertions i_lpr_regs_assertions (.clk_sys, .nrst, .clk_en, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .lane_pll_turn_on, .lane_pll_cal_start,
  .equalizer_power_select, .equalizer_bias_trim, .ref_predivide_select, .ref_predivide_factor,
  .lane_pll_filter_a);
`default_nettype wire

// *** sim/lpr_regs_tb.sv ***
// self-checking bench for the lane pll register bank
`timescale 1ns/1ps
`default_nettype none
module lpr_regs_tb import lpr_pkg::*;;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic [9:0]  reg_addr = 10'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid;
  logic [3:0]  fl = 4'h0;
  logic [7:0]  rnd = 8'h54;
  logic [15:0] e;
  logic [15:0] q[$];
  int          error_cnt = 0;
  int          cmp_count = 0;
  logic [9:0]  ad[12] = '{10'h268, 10'h280, 10'h281, 10'h284, 10'h285, 10'h286, 10'h287,
                          10'h289, 10'h28a, 10'h28b, 10'h290, 10'h282};
  logic [7:0]  rv[12] = '{8'h62, 8'h00, 8'h00, 8'h77, 8'h87, 8'h08, 8'h3f, 8'h00, 8'h2b,
                          8'h7f, 8'h83, 8'h00};
  logic [7:0]  wm[12] = '{8'hff, 8'h05, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'hff,
                          8'hff, 8'hff, 8'h00};
  logic [7:0]  rc[12] = '{8'h00, 8'h00, 8'h00, 8'h62, 8'hc9, 8'h0e, 8'h12, 8'h00, 8'h7b,
                          8'h00, 8'h89, 8'h00};
  lpr_regs i_lpr_regs (
    .clk_sys, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .pll_lock_in(fl[0]), .pll_cal_ok_in(fl[3]), .pll_band_high_in(fl[2]),
    .pll_band_low_in(fl[1]), .lane_pll_turn_on(), .lane_pll_cal_start(),
    .equalizer_power_select(), .equalizer_bias_trim(), .ref_predivide_select(),
    .ref_predivide_factor(), .ref_config_bit(), .lane_pll_filter_a(), .lane_pll_filter_b(),
    .lane_pll_filter_c(), .lane_pll_pump_a(), .lane_pll_osc_regulator(),
    .lane_pll_powerdown_a(), .lane_pll_varactor_a()
  );
  always #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic stop_test();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, x, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // zero mask marks a poll whose value is not compared
  task automatic rd(input logic [9:0] a, input logic [7:0] x, input logic [7:0] m);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    q.push_back({m, x});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic poll();
    for (int n = 0; n < 20; n++) begin
      rd(LPR_OFS_PLL_STATE, 8'h00, 8'h00);
      #1;
      if (reg_rdata[3] === 1'b1) return;
    end
    error_cnt++;
    $display("Error at %0t: expected %h got %h", $time, 8'h08, reg_rdata);
    stop_test();
  endtask
  always @(posedge clk_sys) begin
    if (reg_rvalid === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      if (e[15:8] != 8'h00) chk(e[7:0] & e[15:8], reg_rdata & e[15:8]);
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 12; i++) rd(ad[i], rv[i], 8'hff);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      if (i == 0) rnd[5:0] = 6'h22;
      wr(ad[i], rnd);
      rd(ad[i], rnd & wm[i], 8'hff);
    end
    $display("access kinds done");
    for (int c = 0; c < 3; c++) begin
      wr(LPR_OFS_EQ_BIAS, {c[1:0], 6'h22});
      rd(LPR_OFS_EQ_BIAS, {c[1:0], 6'h22}, 8'hff);
      wr(LPR_OFS_REF_DIVIDE, {6'h01, c[1:0]});
      rd(LPR_OFS_REF_DIVIDE, {6'h01, c[1:0]}, 8'hff);
    end
    for (int i = 3; i < 11; i++) begin
      if (i != 7) begin
        wr(ad[i], rc[i]);
        rd(ad[i], rc[i], 8'hff);
      end
    end
    // write while frozen must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(LPR_OFS_FILTER_A, 8'h00);
    clk_en <= 1'b1;
    rd(LPR_OFS_FILTER_A, rc[3], 8'hff);
    $display("modes done");
    for (int k = 1; k < 3; k++) begin
      rnd = lfsr(rnd);
      fl <= {1'b1, k[1], k[0], rnd[0]};
      wr(LPR_OFS_PLL_ENABLE, 8'h00);
      rd(LPR_OFS_PLL_STATE, 8'h00, 8'hff);
      wr(LPR_OFS_PLL_ENABLE, 8'h01);
      poll();
      rd(LPR_OFS_PLL_STATE, {2'h0, fl[2:1], 1'b1, 2'h0, fl[0]}, 8'hff);
      wr(LPR_OFS_PLL_ENABLE, 8'h05);
      poll();
      rd(LPR_OFS_PLL_STATE, {2'h0, fl[2:1], 1'b1, 2'h0, fl[0]}, 8'hff);
    end
    repeat (3) @(posedge clk_sys);
    $display("calibration done");
    stop_test();
  end
endmodule // lpr_regs_tb
`default_nettype wire
